//--- rtl/rfsel_pkg.sv
// Constants and types of the reference frequency selection block
package rfsel_pkg;

    // ************************************************************
    // Register map (APB byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_STAT  = 8'h04;
    localparam logic [7:0] ADDR_FREQ  = 8'h08;
    localparam logic [7:0] ADDR_TRIM  = 8'h0C;
    localparam logic [7:0] ADDR_SNIFF = 8'h10;
    localparam logic [7:0] ADDR_SMAX  = 8'h14;
    localparam logic [7:0] ADDR_BAUD  = 8'h18;

    localparam int CTRL_TCXO   = 0;
    localparam int CTRL_SLEEP  = 1;
    localparam int CTRL_INTLPO = 2;
    localparam int CTRL_W      = 3;

    // ************************************************************
    // Frequencies in kHz
    // ************************************************************
    localparam logic [15:0] KHZ_20 = 16'h4E20;
    localparam logic [15:0] KHZ_26 = 16'h6590;
    localparam int NUM_STD = 17;
    localparam logic [15:0] STD_KHZ [NUM_STD] = '{
        16'h2EE0, 16'h32C8, 16'h3840, 16'h3C00, 16'h3F48, 16'h41A0,
        16'h4650, 16'h4B00, 16'h4BF0, 16'h4CE0, 16'h4D58, 16'h4E20,
        16'h5DC0, 16'h6590, 16'h8340, 16'h9218, 16'h9600};

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int LPO_TMO_US    = 100;
    localparam int LPO_PERIOD_NS = 30518;
    localparam int DET_WIN       = 32;
    localparam logic [17:0] DET_MUL = 18'h00003;
    localparam int DET_SH        = 7;
    localparam logic [15:0] DET_TOL_KHZ   = 16'h0032;
    localparam logic [15:0] SNIFF_MAX_RST = 16'h0320;

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_NVRD  = 7'h02,
        S_LPCHK = 7'h04,
        S_DET   = 7'h08,
        S_BWAIT = 7'h10,
        S_BMEAS = 7'h20,
        S_DONE  = 7'h40
    } rfsel_state_t;

    typedef enum logic [2:0] {
        SRC_NONE  = 3'h0,
        SRC_STRAP = 3'h1,
        SRC_NV    = 3'h2,
        SRC_DET   = 3'h3,
        SRC_BAUD  = 3'h4
    } rfsel_src_t;

    typedef struct packed {
        rfsel_state_t        st;
        logic                strap_s1, strap_s2;
        logic                lpo_s1, lpo_s2, lpo_d;
        logic                ref_s1, ref_s2, ref_d;
        logic                rxd_s1, rxd_s2, rxd_d;
        logic [31:0]         tmo;
        logic [5:0]          lpo_cnt;
        logic [15:0]         ref_cnt;
        logic [15:0]         nvf;
        logic                nv_ok;
        logic                nv_req;
        logic [15:0]         freq;
        logic [15:0]         trim;
        rfsel_src_t          src;
        logic                valid;
        logic                lpo_ext;
        logic [15:0]         baud;
        logic [CTRL_W-1:0]   ctrl;
        logic                clk_req;
        logic [15:0]         sniff_int;
        logic [15:0]         sniff_max;
        logic [15:0]         sniff_cnt;
        logic [15:0]         div_cnt;
        logic                sniff_evt;
        logic [31:0]         prdata;
        logic                pslverr;
    } rfsel_regs_t;

    localparam rfsel_regs_t RST_VAL = '{st: S_IDLE, src: SRC_NONE, rxd_s1: 1'b1,
        rxd_s2: 1'b1, rxd_d: 1'b1, clk_req: 1'b1, sniff_max: SNIFF_MAX_RST,
        default: '0};

endpackage

//--- rtl/rfsel_top.sv
// Reference frequency selection, trim, clock request and sniff timing
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module rfsel_top
    import rfsel_pkg::*;
#(
    parameter int LPO_TMO_CYC = LPO_TMO_US * 1000 / CLK_PERIOD_NS,
    parameter int INT_DIV     = LPO_PERIOD_NS / CLK_PERIOD_NS
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        STRAP_IN,
    input  wire logic        LOW_POWER_CLOCK,
    input  wire logic        CRYSTAL_CLOCK,
    input  wire logic        UART_RXD,
    input  wire logic        AUTOBAUD_EN,
    input  wire logic        HOST_IS_UART,
    input  wire logic        NV_PRESENT,
    output logic             NV_REQ,
    input  wire logic        NV_DONE,
    input  wire logic        NV_HAS_FREQ,
    input  wire logic [15:0] NV_FREQ_KHZ,
    input  wire logic        NV_HAS_TRIM,
    input  wire logic [15:0] NV_TRIM,
    output logic      [15:0] FREQ_KHZ,
    output logic      [2:0]  FREQ_SRC,
    output logic             FREQ_VALID,
    output logic             IF_EN,
    output logic      [15:0] SYNTH_TRIM,
    output logic      [15:0] BAUD_DIV,
    output logic             CLK_REQ,
    output logic             LP_CLK_EXT,
    output logic             SNIFF_EVT
);
    import rfsel_pkg::*;

    localparam logic [31:0] TMO_LAST = 32'(LPO_TMO_CYC - 1);
    localparam logic [15:0] DIV_LAST = 16'(INT_DIV - 1);
    localparam logic [5:0]  WIN_LAST = 6'(DET_WIN);

    rfsel_regs_t r;
    rfsel_regs_t n;

    logic        lpo_rise;
    logic        ref_rise;
    logic        rxd_fall;
    logic        rxd_rise;
    logic        tmo_end;
    logic        det_end;
    logic        use_ext;
    logic        lp_tick;
    logic        setup;
    logic        wr;
    logic        mapped;
    logic        hit;
    logic [15:0] hit_khz;
    logic [15:0] meas;
    logic [15:0] diff;
    logic [17:0] m3;
    logic [15:0] fb_freq;
    rfsel_src_t  fb_src;
    logic [15:0] eff_int;

    // ************************************************************
    // Edge and event terms
    // ************************************************************
    assign lpo_rise = r.lpo_s2 & ~r.lpo_d;
    assign ref_rise = r.ref_s2 & ~r.ref_d;
    assign rxd_fall = ~r.rxd_s2 & r.rxd_d;
    assign rxd_rise = r.rxd_s2 & ~r.rxd_d;
    // A second edge beats the timeout in the same cycle
    assign tmo_end  = (r.st == S_LPCHK) && (r.tmo == TMO_LAST)
                      && !(lpo_rise && r.lpo_cnt != 6'h00);
    assign det_end  = (r.st == S_DET) && lpo_rise && (r.lpo_cnt == WIN_LAST);
    assign use_ext  = r.lpo_ext & ~r.ctrl[CTRL_INTLPO];
    assign lp_tick  = use_ext ? lpo_rise : (r.div_cnt == DIV_LAST);
    assign setup    = PSEL & ~PENABLE;
    assign wr       = PSEL & PENABLE & PWRITE & ~r.pslverr;

    // Fallback when no detection or autobaud applies
    assign fb_freq  = r.nv_ok ? r.nvf : (r.strap_s2 ? KHZ_20 : KHZ_26);
    assign fb_src   = r.nv_ok ? SRC_NV : SRC_STRAP;

    // ************************************************************
    // Frequency detection match
    // ************************************************************
    // Ref edges over 32 low power periods give about 1.024 kHz each
    assign m3   = 18'(r.ref_cnt) * DET_MUL;
    assign meas = r.ref_cnt + 16'(m3 >> DET_SH);

    always_comb begin
        hit = 1'b0;
        hit_khz = 16'h0000;
        diff = 16'h0000;
        for (int i = 0; i < NUM_STD; i++) begin
            diff = (meas > STD_KHZ[i]) ? meas - STD_KHZ[i] : STD_KHZ[i] - meas;
            if (!hit && diff <= DET_TOL_KHZ) begin
                hit = 1'b1;
                hit_khz = STD_KHZ[i];
            end
        end
    end

    always_comb begin
        case (PADDR)
            ADDR_CTRL, ADDR_STAT, ADDR_FREQ, ADDR_TRIM,
            ADDR_SNIFF, ADDR_SMAX, ADDR_BAUD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign eff_int = (!use_ext && r.sniff_int > r.sniff_max) ? r.sniff_max
                                                              : r.sniff_int;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = r;
        n.sniff_evt = 1'b0;
        n.strap_s1 = STRAP_IN;
        n.strap_s2 = r.strap_s1;
        n.lpo_s1 = LOW_POWER_CLOCK;
        n.lpo_s2 = r.lpo_s1;
        n.lpo_d = r.lpo_s2;
        n.ref_s1 = CRYSTAL_CLOCK;
        n.ref_s2 = r.ref_s1;
        n.ref_d = r.ref_s2;
        n.rxd_s1 = UART_RXD;
        n.rxd_s2 = r.rxd_s1;
        n.rxd_d = r.rxd_s2;

        case (r.st)
            S_IDLE: begin
                n.tmo = 32'h0000_0000;
                n.lpo_cnt = 6'h00;
                if (NV_PRESENT) begin
                    n.nv_req = 1'b1;
                    n.st = S_NVRD;
                end else begin
                    n.st = S_LPCHK;
                end
            end
            S_NVRD: begin
                if (NV_DONE) begin
                    n.nv_req = 1'b0;
                    if (NV_HAS_TRIM) begin
                        n.trim = NV_TRIM;
                    end
                    if (NV_HAS_FREQ) begin
                        n.nvf = NV_FREQ_KHZ;
                        n.nv_ok = 1'b1;
                    end
                    n.st = S_LPCHK;
                end
            end
            S_LPCHK: begin
                n.tmo = r.tmo + 32'h0000_0001;
                if (lpo_rise) begin
                    n.lpo_cnt = r.lpo_cnt + 6'h01;
                end
                if (lpo_rise && r.lpo_cnt != 6'h00) begin
                    n.lpo_ext = 1'b1;
                    n.lpo_cnt = 6'h01;
                    n.ref_cnt = 16'h0000;
                    n.st = S_DET;
                end else if (tmo_end) begin
                    if (AUTOBAUD_EN && HOST_IS_UART) begin
                        n.st = S_BWAIT;
                    end else begin
                        n.freq = fb_freq;
                        n.src = fb_src;
                        n.valid = 1'b1;
                        n.st = S_DONE;
                    end
                end
            end
            S_DET: begin
                if (ref_rise && r.ref_cnt != 16'hFFFF) begin
                    n.ref_cnt = r.ref_cnt + 16'h0001;
                end
                if (lpo_rise) begin
                    n.lpo_cnt = r.lpo_cnt + 6'h01;
                end
                if (det_end) begin
                    n.freq = hit ? hit_khz : fb_freq;
                    n.src = hit ? SRC_DET : fb_src;
                    n.valid = 1'b1;
                    n.st = S_DONE;
                end
            end
            S_BWAIT: begin
                // Waits for host traffic; no frequency is assumed meanwhile
                if (rxd_fall) begin
                    n.baud = 16'h0001;
                    n.st = S_BMEAS;
                end
            end
            S_BMEAS: begin
                if (r.baud != 16'hFFFF) begin
                    n.baud = r.baud + 16'h0001;
                end
                if (rxd_rise) begin
                    n.freq = 16'h0000;
                    n.src = SRC_BAUD;
                    n.valid = 1'b1;
                    n.st = S_DONE;
                end
            end
            S_DONE: begin
                n.st = S_DONE;
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase

        // Internal low power clock from main clock divider
        n.div_cnt = (r.div_cnt == DIV_LAST) ? 16'h0000 : r.div_cnt + 16'h0001;
        if (lp_tick && eff_int != 16'h0000) begin
            if (r.sniff_cnt >= eff_int - 16'h0001) begin
                n.sniff_cnt = 16'h0000;
                n.sniff_evt = 1'b1;
            end else begin
                n.sniff_cnt = r.sniff_cnt + 16'h0001;
            end
        end

        // TCXO may stop only when enabled and system asleep
        n.clk_req = ~(r.ctrl[CTRL_TCXO] & r.ctrl[CTRL_SLEEP]);

        // ********************************************************
        // APB slave, zero wait, data captured in setup
        // ********************************************************
        if (setup) begin
            n.pslverr = ~mapped;
            case (PADDR)
                ADDR_CTRL:  n.prdata = {29'h0, r.ctrl};
                ADDR_STAT:  n.prdata = {26'h0, r.clk_req, use_ext, r.valid, r.src};
                ADDR_FREQ:  n.prdata = {16'h0, r.freq};
                ADDR_TRIM:  n.prdata = {16'h0, r.trim};
                ADDR_SNIFF: n.prdata = {16'h0, r.sniff_int};
                ADDR_SMAX:  n.prdata = {16'h0, r.sniff_max};
                ADDR_BAUD:  n.prdata = {16'h0, r.baud};
                default:    n.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (PADDR)
                ADDR_CTRL:  n.ctrl = PWDATA[CTRL_W-1:0];
                ADDR_TRIM:  n.trim = PWDATA[15:0];
                ADDR_SNIFF: n.sniff_int = PWDATA[15:0];
                ADDR_SMAX:  n.sniff_max = PWDATA[15:0];
                default:    n.ctrl = r.ctrl;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= RST_VAL;
        end else if (CE) begin
            r <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PREADY     = 1'b1;
    assign PRDATA     = r.prdata;
    assign PSLVERR    = r.pslverr & PSEL & PENABLE;
    assign NV_REQ     = r.nv_req;
    assign FREQ_KHZ   = r.freq;
    assign FREQ_SRC   = r.src;
    assign FREQ_VALID = r.valid;
    assign IF_EN      = r.valid;
    assign SYNTH_TRIM = r.trim;
    assign BAUD_DIV   = r.baud;
    assign CLK_REQ    = r.clk_req;
    assign LP_CLK_EXT = use_ext;
    assign SNIFF_EVT  = r.sniff_evt;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_strap_hi;
        @(posedge CLK) disable iff (RST)
        (CE && tmo_end && !(AUTOBAUD_EN && HOST_IS_UART) && !r.nv_ok && r.strap_s2)
        |=> (r.freq == KHZ_20 && r.src == SRC_STRAP);
    endproperty
    a_strap_hi: assert property (p_strap_hi) else $error("strap high not 20 MHz");

    property p_strap_lo;
        @(posedge CLK) disable iff (RST)
        (CE && tmo_end && !(AUTOBAUD_EN && HOST_IS_UART) && !r.nv_ok && !r.strap_s2)
        |=> (r.freq == KHZ_26 && r.src == SRC_STRAP);
    endproperty
    a_strap_lo: assert property (p_strap_lo) else $error("strap low not 26 MHz");

    property p_autobaud;
        @(posedge CLK) disable iff (RST)
        (CE && tmo_end && AUTOBAUD_EN && HOST_IS_UART) |=> (r.st == S_BWAIT);
    endproperty
    a_autobaud: assert property (p_autobaud) else $error("autobaud not entered");

    property p_nv_freq;
        @(posedge CLK) disable iff (RST)
        (CE && tmo_end && !(AUTOBAUD_EN && HOST_IS_UART) && r.nv_ok)
        |=> (r.src == SRC_NV && r.freq == $past(r.nvf));
    endproperty
    a_nv_freq: assert property (p_nv_freq) else $error("nvram freq not used");

    property p_uart_only;
        @(posedge CLK) disable iff (RST)
        (CE && tmo_end && !HOST_IS_UART) |=> (r.st == S_DONE);
    endproperty
    a_uart_only: assert property (p_uart_only) else $error("autobaud without uart");

    property p_nv_trim;
        @(posedge CLK) disable iff (RST)
        (CE && r.st == S_NVRD && NV_DONE && NV_HAS_TRIM && !wr)
        |=> (SYNTH_TRIM == $past(NV_TRIM)) ##1 (r.st != S_NVRD);
    endproperty
    a_nv_trim: assert property (p_nv_trim) else $error("nvram trim lost");

    property p_detect;
        @(posedge CLK) disable iff (RST)
        (CE && det_end && hit) |=> (r.src == SRC_DET && FREQ_KHZ == $past(hit_khz));
    endproperty
    a_detect: assert property (p_detect) else $error("detected freq not taken");

    property p_clkreq;
        @(posedge CLK) disable iff (RST)
        (CE && r.ctrl[CTRL_TCXO] && r.ctrl[CTRL_SLEEP]) |=> !CLK_REQ;
    endproperty
    a_clkreq: assert property (p_clkreq) else $error("clock request not dropped");

    property p_hold;
        @(posedge CLK) disable iff (RST)
        (r.st == S_DONE && !(wr && PADDR == ADDR_TRIM))
        |=> ($stable(FREQ_KHZ) && $stable(SYNTH_TRIM) && FREQ_VALID);
    endproperty
    a_hold: assert property (p_hold) else $error("settled setting changed");

endmodule // rfsel_top

//--- verif/rfsel_far_model.sv
// Far-side model: NVRAM parameter store, low-power clock and crystal
module rfsel_far_model (
    input  wire logic        clk,
    input  wire logic        nv_req,
    input  wire logic [3:0]  nv_lat,
    input  wire logic        has_freq,
    input  wire logic [15:0] freq,
    input  wire logic        has_trim,
    input  wire logic [15:0] trim,
    input  wire logic        lpo_on,
    output logic             nv_done,
    output logic             nv_has_freq,
    output logic      [15:0] nv_freq,
    output logic             nv_has_trim,
    output logic      [15:0] nv_trim,
    output logic             lp_clk,
    output logic             crystal_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r = '0;
    logic [3:0] lp_cnt = '0;
    logic       lp_r   = 1'b0;
    logic       xt_r   = 1'b0;
    logic       done_r = 1'b0;
    // Gate input of the TCXO OR option, held actively low so the crystal passes
    logic       osc_gate_input = 1'b0;
    // Too slow a crystal for any table entry in the short window
    initial forever #20 xt_r = ~xt_r;
    always @(posedge clk) begin
        done_r <= 1'b0;
        if (nv_req && !done_r) begin
            if (wait_r == nv_lat) begin
                done_r <= 1'b1;
                wait_r <= '0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
        lp_cnt <= lp_cnt + 4'h1;
        if (lpo_on && lp_cnt == 4'hF)
            lp_r <= ~lp_r;
    end
    // Data lines show the inverse outside the answer cycle
    assign nv_done     = done_r;
    assign nv_has_freq = done_r ? has_freq : ~has_freq;
    assign nv_freq     = done_r ? freq : ~freq;
    assign nv_has_trim = done_r ? has_trim : ~has_trim;
    assign nv_trim     = done_r ? trim : ~trim;
    assign lp_clk      = lp_r;
    assign crystal_clock        = xt_r | osc_gate_input;
endmodule // rfsel_far_model

//--- verif/test_reference_frequency_select.sv
// Self-checking bench of the reference frequency selection block
module test_reference_frequency_select
    import rfsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk = 1'b0, rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic        strap = 1'b1, ab_en = 1'b0, is_uart = 1'b0, nv_pres = 1'b0;
    logic        lpo_on = 1'b0, has_f = 1'b0, rxd = 1'b1, v_d = 1'b0;
    logic [3:0]  lat = '0;
    logic [15:0] nvf = '0, nvt = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, nv_req, nv_done, nv_hf, nv_ht, lpc, crystal_clock;
    logic [15:0] nv_f, nv_t, freq, strim, baud;
    logic [2:0]  src;
    logic        valid, if_en, creq, lpext, sevt;
    logic [32:0] rd_q[$];
    logic [19:0] sel_q[$];
    int          err_count = 0, n_checks = 0, cyc = 0;
    // Setting {strap, autobaud, uart host, nvram, lp clock, nv freq}, source
    localparam logic [8:0] TESTS [8] = '{
        {6'b100000, 3'h1},
        {6'b000000, 3'h1},
        {6'b000101, 3'h2},
        {6'b100100, 3'h1},
        {6'b011000, 3'h4},
        {6'b110000, 3'h1},
        {6'b011010, 3'h1},
        {6'b011101, 3'h4}};

    rfsel_top #(.LPO_TMO_CYC(200), .INT_DIV(8)) DUT (
        .CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .STRAP_IN(strap), .LOW_POWER_CLOCK(lpc), .CRYSTAL_CLOCK(crystal_clock), .UART_RXD(rxd),
        .AUTOBAUD_EN(ab_en), .HOST_IS_UART(is_uart), .NV_PRESENT(nv_pres), .NV_REQ(nv_req),
        .NV_DONE(nv_done), .NV_HAS_FREQ(nv_hf), .NV_FREQ_KHZ(nv_f), .NV_HAS_TRIM(nv_ht),
        .NV_TRIM(nv_t), .FREQ_KHZ(freq), .FREQ_SRC(src), .FREQ_VALID(valid), .IF_EN(if_en),
        .SYNTH_TRIM(strim), .BAUD_DIV(baud), .CLK_REQ(creq), .LP_CLK_EXT(lpext),
        .SNIFF_EVT(sevt));
    rfsel_far_model u_far (.clk(clk), .nv_req(nv_req), .nv_lat(lat), .has_freq(has_f),
        .freq(nvf), .has_trim(1'b1), .trim(nvt), .lpo_on(lpo_on), .nv_done(nv_done),
        .nv_has_freq(nv_hf), .nv_freq(nv_f), .nv_has_trim(nv_ht), .nv_trim(nv_t),
        .lp_clk(lpc), .crystal_clock(crystal_clock));

    initial forever #5 clk = ~clk;
    // ************************************************************
    // Comparison and bus tasks
    // ************************************************************
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [32:0] e);
        cmp({pslverr, prdata}, e, "read data");
    endtask
    task automatic chk_sel(input logic [19:0] e);
        cmp(33'({src, freq, if_en}), 33'(e), "selection");
    endtask
    task automatic chk_out(input logic [32:0] g, input logic [32:0] e);
        cmp(g, e, "output");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge clk);
        if (!w)
            rd_q.push_back(e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // The wait ends on the first clock edge that sees pready high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sniff_gap(input int exp);
        int n;
        n = 0;
        while (sevt !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        n = 1;
        while (sevt !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk_out(33'(n), 33'(exp));
    endtask
    task automatic sel_test(input logic [5:0] cfg, input logic [2:0] es);
        int          n;
        logic [15:0] f, ef;
        @(posedge clk);
        f = 16'h2EE0 + 16'($urandom_range(40000));
        case (es)
            3'h2:    ef = f;
            3'h4:    ef = 16'h0000;
            default: ef = cfg[5] ? KHZ_20 : KHZ_26;
        endcase
        {strap, ab_en, is_uart, nv_pres, lpo_on, has_f} <= cfg;
        nvf <= f;
        nvt <= 16'($urandom());
        lat <= 4'($urandom_range(15));
        sel_q.push_back({es, ef, 1'b1});
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Start bit arrives late, and during detection in the lp clock case
        repeat (300) @(posedge clk);
        rxd <= 1'b0;
        repeat (52) @(posedge clk);
        rxd <= 1'b1;
        n = 0;
        while (valid !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk_out(33'(strim), cfg[2] ? 33'(nvt) : 33'h0);
        chk_out(33'(lpext), 33'(cfg[1]));
        if (es == 3'h4)
            chk_out(33'(baud > 16'h002F && baud < 16'h0039), 33'h1);
        apb(1'b0, ADDR_STAT, '0, {28'h1, cfg[1], 1'b1, es});
        apb(1'b0, ADDR_FREQ, '0, {17'h0, ef});
        chk_out(33'(sel_q.size()), 33'h0);
    endtask
    // ************************************************************
    // Watcher and main sequence
    // ************************************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        v_d <= valid;
        if (psel && penable && pready && !pwrite && rd_q.size() > 0)
            chk_rd(rd_q.pop_front());
        if (valid === 1'b1 && v_d !== 1'b1 && sel_q.size() > 0)
            chk_sel(sel_q.pop_front());
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        logic [15:0] t;
        void'($urandom(32'hDBCC));
        for (int i = 0; i < 8; i++) begin
            sel_test(TESTS[i][8:3], TESTS[i][2:0]);
            $display("test selection %0d done", i);
        end
        apb(1'b0, ADDR_SMAX, '0, {17'h0, SNIFF_MAX_RST});
        apb(1'b0, 8'h1C, '0, {1'b1, 32'h0});
        t = 16'($urandom());
        apb(1'b1, ADDR_TRIM, {16'h0, t}, '0);
        apb(1'b0, ADDR_TRIM, '0, {17'h0, t});
        chk_out(33'(strim), 33'(t));
        apb(1'b1, ADDR_CTRL, 32'h3, '0);
        repeat (3) @(posedge clk);
        chk_out(33'(creq), 33'h0);
        apb(1'b1, ADDR_CTRL, 32'h1, '0);
        repeat (3) @(posedge clk);
        chk_out(33'(creq), 33'h1);
        $display("test registers done");
        apb(1'b1, ADDR_SNIFF, 32'h2, '0);
        sniff_gap(16);
        apb(1'b1, ADDR_SMAX, 32'h1, '0);
        apb(1'b1, ADDR_SNIFF, 32'h3, '0);
        sniff_gap(8);
        $display("test sniff done");
        summarize();
    end
endmodule // test_reference_frequency_select
